// ===== design/psv_pkg.sv
// shared constants and types for the program space read window
package psv_pkg;

  // register byte offsets on the ahb-lite bus
  localparam logic [4:0] PSV_OFF_RPAGE  = 5'h00;
  localparam logic [4:0] PSV_OFF_WPAGE  = 5'h04;
  localparam logic [4:0] PSV_OFF_STATUS = 5'h08;
  localparam logic [4:0] PSV_OFF_MASK   = 5'h0c;
  localparam logic [4:0] PSV_OFF_LAST   = 5'h10;

  // reset values
  localparam logic [9:0] PSV_RPAGE_RST = 10'h000;
  localparam logic [9:0] PSV_WPAGE_RST = 10'h000;
  localparam logic [1:0] PSV_MASK_RST  = 2'h0;

  // page register fields and the window address bit
  localparam int PSV_PG_ENABLE = 9;
  localparam int PSV_PG_UPPER  = 8;
  localparam int PSV_EA_MSB    = 15;

  // status and mask bit positions
  localparam int PSV_ST_TRAP  = 0;
  localparam int PSV_ST_WDROP = 1;

  // extra instruction cycles for window reads
  localparam logic [1:0] PSV_EXTRA_MOV   = 2'h1;
  localparam logic [1:0] PSV_EXTRA_OTHER = 2'h2;
  localparam logic [1:0] PSV_EXTRA_EDGE  = 2'h2;
  localparam logic [1:0] PSV_EXTRA_MID   = 2'h0;

  // request sequencer states
  typedef enum logic [1:0] {
    PSV_IDLE,
    PSV_FETCH,
    PSV_STALL
  } psv_state_t;

endpackage : psv_pkg

// ===== design/psv_addr_map.sv
// address translation from data-space address to program address
`timescale 1ns/1ps
module psv_addr_map
  import psv_pkg::*;
(
  input  wire logic [15:0] ea,
  input  wire logic        write,
  input  wire logic [9:0]  rpage,
  input  wire logic [9:0]  wpage,
  output logic             win_read,
  output logic             win_write,
  output logic             trap,
  output logic [22:0]      paddr,
  output logic             upper
);

  // window decode and address build
  always_comb begin
    win_read  = !write && ea[PSV_EA_MSB] && rpage[PSV_PG_ENABLE];
    win_write = write && ea[PSV_EA_MSB] && rpage[PSV_PG_ENABLE];
    trap      = ea[PSV_EA_MSB] && (write ? (wpage == 10'h000) : (rpage == 10'h000));
    upper     = rpage[PSV_PG_UPPER];
    paddr     = {rpage[7:0], ea[14:1], upper};
  end

endmodule : psv_addr_map

// ===== design/psv_cycle_cost.sv
// extra instruction cycles charged to a window read
`timescale 1ns/1ps
module psv_cycle_cost
  import psv_pkg::*;
(
  input  wire logic       in_repeat,
  input  wire logic       mov_class,
  input  wire logic       rpt_first,
  input  wire logic       rpt_last,
  input  wire logic       irq_exit,
  input  wire logic       irq_reentry,
  output logic [1:0]      extra
);

  // repeat edges cost two, middle iterations none
  always_comb begin
    if (!in_repeat) begin
      extra = mov_class ? PSV_EXTRA_MOV : PSV_EXTRA_OTHER;
    end else if (rpt_first || rpt_last || irq_exit || irq_reentry) begin
      extra = PSV_EXTRA_EDGE;
    end else begin
      extra = PSV_EXTRA_MID;
    end
  end

endmodule : psv_cycle_cost

// ===== design/psv_window.sv
// program space read window: cpu read path, flash fetch and ahb registers
`timescale 1ns/1ps
module psv_window
  import psv_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite register slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // cpu data-space access
  input  wire logic        cpu_req,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_write,
  input  wire logic        cpu_byte,
  input  wire logic        cpu_mov_class,
  input  wire logic        cpu_in_repeat,
  input  wire logic        cpu_rpt_first,
  input  wire logic        cpu_rpt_last,
  input  wire logic        cpu_irq_exit,
  input  wire logic        cpu_irq_reentry,
  output logic             cpu_ready,
  output logic             cpu_done,
  output logic             cpu_window_hit,
  output logic [15:0]      cpu_rdata,
  output logic [1:0]       cpu_extra_cycles,
  output logic             addr_err_trap,
  // program flash read port
  output logic             prog_req,
  output logic [22:0]      prog_addr,
  input  wire logic        prog_rvalid,
  input  wire logic [23:0] prog_rdata,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    psv_state_t  st;
    logic [9:0]  rpage;
    logic [9:0]  wpage;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        ahb_ph;
    logic        ahb_wr;
    logic [4:0]  ahb_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        ready;
    logic        done;
    logic        hit;
    logic [15:0] rdata;
    logic [1:0]  extra;
    logic [1:0]  cnt;
    logic        trap;
    logic        prog_req;
    logic [22:0] prog_addr;
    logic        upper;
    logic        byte_rd;
    logic        byte_hi;
    logic        irq;
  } psv_regs_t;

  psv_regs_t state_reg;
  psv_regs_t state_next;

  logic        map_win_read;
  logic        map_win_write;
  logic        map_trap;
  logic [22:0] map_paddr;
  logic        map_upper;
  logic [1:0]  cost_extra;
  logic [1:0]  st_set;
  logic [1:0]  st_clr;
  logic        addr_ok;

  // translation of the cpu address through the page registers
  psv_addr_map u_map (
    .ea        (cpu_addr),
    .write     (cpu_write),
    .rpage     (state_reg.rpage),
    .wpage     (state_reg.wpage),
    .win_read  (map_win_read),
    .win_write (map_win_write),
    .trap      (map_trap),
    .paddr     (map_paddr),
    .upper     (map_upper)
  );

  // cycle penalty for the current instruction
  psv_cycle_cost u_cost (
    .in_repeat   (cpu_in_repeat),
    .mov_class   (cpu_mov_class),
    .rpt_first   (cpu_rpt_first),
    .rpt_last    (cpu_rpt_last),
    .irq_exit    (cpu_irq_exit),
    .irq_reentry (cpu_irq_reentry),
    .extra       (cost_extra)
  );

  // pick word or byte from the returned program word
  function automatic logic [15:0] psv_pick(input logic [23:0] w, input logic up,
                                           input logic bsel, input logic bhi);
    logic [15:0] wd;
    wd = up ? {8'h00, w[23:16]} : w[15:0];
    if (bsel) begin
      psv_pick = {8'h00, (bhi ? wd[15:8] : wd[7:0])};
    end else begin
      psv_pick = wd;
    end
  endfunction : psv_pick

  // register read mux
  function automatic logic [31:0] psv_rd(input psv_regs_t s, input logic [4:0] a);
    case (a)
      PSV_OFF_RPAGE:  psv_rd = {22'h000000, s.rpage};
      PSV_OFF_WPAGE:  psv_rd = {22'h000000, s.wpage};
      PSV_OFF_STATUS: psv_rd = {30'h00000000, s.status};
      PSV_OFF_MASK:   psv_rd = {30'h00000000, s.mask};
      PSV_OFF_LAST:   psv_rd = {9'h000, s.prog_addr};
      default:        psv_rd = 32'h00000000;
    endcase
  endfunction : psv_rd

  assign addr_ok = (haddr[31:5] == 27'h0000000);

  // next-state logic: ahb slave, cpu sequencer, sticky status
  always_comb begin
    state_next           = state_reg;
    state_next.hreadyout = 1'b1;
    state_next.done      = 1'b0;
    state_next.trap      = 1'b0;
    state_next.prog_req  = 1'b0;
    st_set               = 2'h0;
    st_clr               = 2'h0;

    // data phase of a write
    if (state_reg.ahb_ph && state_reg.ahb_wr) begin
      case (state_reg.ahb_addr)
        PSV_OFF_RPAGE:  state_next.rpage = hwdata[9:0];
        PSV_OFF_WPAGE:  state_next.wpage = hwdata[9:0];
        PSV_OFF_STATUS: st_clr = hwdata[1:0];
        PSV_OFF_MASK:   state_next.mask = hwdata[1:0];
        default:        state_next.rpage = state_reg.rpage;
      endcase
    end

    // address phase capture
    state_next.ahb_ph = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      state_next.ahb_wr   = hwrite;
      state_next.ahb_addr = addr_ok ? haddr[4:0] : 5'h1c;
      state_next.hrdata   = addr_ok ? psv_rd(state_reg, haddr[4:0]) : 32'h00000000;
    end

    case (state_reg.st)
      PSV_IDLE: begin
        if (cpu_req) begin
          state_next.hit = map_win_read;
          if (map_trap) begin
            state_next.trap     = 1'b1;
            state_next.done     = 1'b1;
            state_next.rdata    = 16'h0000;
            st_set[PSV_ST_TRAP] = 1'b1;
          end else if (map_win_read) begin
            state_next.prog_req  = 1'b1;
            state_next.prog_addr = map_paddr;
            state_next.upper     = map_upper;
            state_next.byte_rd   = cpu_byte;
            state_next.byte_hi   = cpu_addr[0];
            state_next.extra     = cost_extra;
            state_next.ready     = 1'b0;
            state_next.st        = PSV_FETCH;
          end else begin
            // not a window read; writes into the window are dropped
            state_next.done      = 1'b1;
            state_next.rdata     = 16'h0000;
            state_next.extra     = 2'h0;
            st_set[PSV_ST_WDROP] = map_win_write;
          end
        end
      end
      PSV_FETCH: begin
        if (prog_rvalid) begin
          state_next.rdata = psv_pick(prog_rdata, state_reg.upper, state_reg.byte_rd, state_reg.byte_hi);
          state_next.cnt   = state_reg.extra;
          if (state_reg.extra == 2'h0) begin
            state_next.done  = 1'b1;
            state_next.ready = 1'b1;
            state_next.st    = PSV_IDLE;
          end else begin
            state_next.st = PSV_STALL;
          end
        end
      end
      PSV_STALL: begin
        // hold the cpu for the extra instruction cycles
        if (state_reg.cnt == 2'h1) begin
          state_next.done  = 1'b1;
          state_next.ready = 1'b1;
          state_next.st    = PSV_IDLE;
        end else begin
          state_next.cnt = state_reg.cnt - 2'h1;
        end
      end
      default: begin
        state_next.st    = PSV_IDLE;
        state_next.ready = 1'b1;
      end
    endcase

    // set wins over write-one-to-clear
    state_next.status = (state_reg.status & ~st_clr) | st_set;
    state_next.irq    = |(state_next.status & state_next.mask);
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg           <= '0;
      state_reg.st        <= PSV_IDLE;
      state_reg.rpage     <= PSV_RPAGE_RST;
      state_reg.wpage     <= PSV_WPAGE_RST;
      state_reg.mask      <= PSV_MASK_RST;
      state_reg.hreadyout <= 1'b1;
      state_reg.ready     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register, except hresp which is tied low
  assign hreadyout        = state_reg.hreadyout;
  assign hrdata           = state_reg.hrdata;
  assign hresp            = 1'b0;
  assign cpu_ready        = state_reg.ready;
  assign cpu_done         = state_reg.done;
  assign cpu_window_hit   = state_reg.hit;
  assign cpu_rdata        = state_reg.rdata;
  assign cpu_extra_cycles = state_reg.extra;
  assign addr_err_trap    = state_reg.trap;
  assign prog_req         = state_reg.prog_req;
  assign prog_addr        = state_reg.prog_addr;
  assign irq              = state_reg.irq;

  // zero read page traps on an upper-half read
  trap_zero_page_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg.st == PSV_IDLE && cpu_req && !cpu_write && cpu_addr[15] && state_reg.rpage == 10'h000)
    |=> (addr_err_trap && cpu_done && !prog_req))
    else $error("no trap on zero read page");

  // enabled window read fetches program memory
  window_fetch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg.st == PSV_IDLE && cpu_req && !cpu_write && cpu_addr[15] && state_reg.rpage[9])
    |=> prog_req)
    else $error("window read did not fetch");

  // fetch address built from page and address
  fetch_addr_build_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(prog_req) |-> (prog_addr[22:15] == $past(state_reg.rpage[7:0])
                         && prog_addr[14:1] == $past(cpu_addr[14:1])))
    else $error("program address not page over address");

  // word select drives the odd address bit
  word_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_req |-> (prog_addr[0] == $past(state_reg.rpage[8])))
    else $error("word select mismatch");

  // writes never fetch program memory
  write_no_fetch_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg.st == PSV_IDLE && cpu_req && cpu_write) |=> (!prog_req && cpu_done))
    else $error("write reached program memory");

  // two extra cycles after the fetch
  two_extra_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg.st == PSV_FETCH && prog_rvalid && state_reg.extra == 2'h2)
    |=> !cpu_done ##1 !cpu_done ##1 cpu_done)
    else $error("two-cycle penalty wrong");

  // one extra cycle after the fetch
  one_extra_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg.st == PSV_FETCH && prog_rvalid && state_reg.extra == 2'h1)
    |=> !cpu_done ##1 cpu_done)
    else $error("one-cycle penalty wrong");

  // middle repeat iteration finishes at once
  repeat_mid_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg.st == PSV_FETCH && prog_rvalid && state_reg.extra == 2'h0) |=> cpu_done)
    else $error("middle iteration stalled");

  // phantom byte of an upper word reads zero
  phantom_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (cpu_done && cpu_window_hit && state_reg.upper && state_reg.byte_rd && state_reg.byte_hi)
    |-> cpu_rdata == 16'h0000)
    else $error("phantom byte not zero");

  // interrupt follows unmasked status
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(state_reg.status & state_reg.mask))
    else $error("interrupt level mismatch");

endmodule : psv_window

// ===== verif/psv_flash_model.sv
// program flash model that answers window fetches after a chosen latency
`timescale 1ns/1ps
module psv_flash_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        prog_req,
  input  wire logic [22:0] prog_addr,
  input  wire logic [1:0]  lat,
  output logic             prog_rvalid,
  output logic [23:0]      prog_rdata
);
  logic [22:0] addr_q;
  logic [2:0]  wait_q;
  logic        busy_q;

  // word content is a fixed pattern of its own address; data lines churn outside answers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q      <= 1'b0;
      wait_q      <= 3'h0;
      addr_q      <= 23'h000000;
      prog_rvalid <= 1'b0;
      prog_rdata  <= 24'h000000;
    end else begin
      prog_rvalid <= 1'b0;
      prog_rdata  <= ~prog_rdata;  // never leave a stale word standing
      if (prog_req) begin
        busy_q <= 1'b1;
        addr_q <= prog_addr;
        wait_q <= {1'b0, lat};
      end else if (busy_q && wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end else if (busy_q) begin
        busy_q      <= 1'b0;
        prog_rvalid <= 1'b1;
        prog_rdata  <= {addr_q[7:0] ^ 8'ha5, addr_q[15:0]};
      end
    end
  end
endmodule : psv_flash_model

// ===== verif/tb_psv_window.sv
// self-checking bench for the program space read window
`timescale 1ns/1ps
module tb_psv_window;
  import psv_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, lat, extra_q, ex;
  logic        cpu_req, cpu_write, cpu_byte, cpu_mov_class, cpu_in_repeat, cpu_rpt_first;
  logic        cpu_rpt_last, cpu_irq_exit, cpu_irq_reentry, cpu_ready, cpu_done, cpu_window_hit;
  logic        addr_err_trap, prog_req, prog_rvalid, hit_q, trap_q;
  logic [15:0] cpu_addr, cpu_rdata, v16, a;
  logic [1:0]  cpu_extra_cycles;
  logic [22:0] prog_addr, pa;
  logic [23:0] prog_rdata;
  logic [9:0]  pg;
  logic [5:0]  cf;
  int          miscompares, cmp_count, cyc, rv_c, nreq, n0, dly;
  logic [9:0]  page_t [5] = '{10'h200, 10'h2ff, 10'h300, 10'h3ff, 10'h25a};
  logic [15:0] addr_t [4] = '{16'h8000, 16'hffff, 16'h800b, 16'hc3c6};

  assign hready = hreadyout;
  initial hclk = 1'b0;
  always #4 hclk = ~hclk;
  // cycle index, cycle of the last flash answer, and fetch count
  always @(posedge hclk) cyc <= cyc + 1;
  always @(posedge hclk) if (prog_rvalid) rv_c <= cyc;
  always @(posedge hclk) if (prog_req) nreq <= nreq + 1;

  psv_window DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
    .cpu_byte(cpu_byte), .cpu_mov_class(cpu_mov_class), .cpu_in_repeat(cpu_in_repeat),
    .cpu_rpt_first(cpu_rpt_first), .cpu_rpt_last(cpu_rpt_last), .cpu_irq_exit(cpu_irq_exit),
    .cpu_irq_reentry(cpu_irq_reentry), .cpu_ready(cpu_ready), .cpu_done(cpu_done),
    .cpu_window_hit(cpu_window_hit), .cpu_rdata(cpu_rdata), .cpu_extra_cycles(cpu_extra_cycles),
    .addr_err_trap(addr_err_trap), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_rvalid(prog_rvalid), .prog_rdata(prog_rdata), .irq(irq));
  psv_flash_model flash (.hclk(hclk), .hresetn(hresetn), .prog_req(prog_req), .prog_addr(prog_addr),
    .lat(lat), .prog_rvalid(prog_rvalid), .prog_rdata(prog_rdata));

  // verdict and end of run
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_rdy

  // one ahb-lite single word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [4:0] off, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {27'h0, off};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rdv = hrdata;
  endtask : ahb

  // one cpu access; records hit, trap, penalty and answer delay at done
  task automatic cpu_acc(input logic [15:0] ad, input logic wr, input logic byt, input logic [5:0] c,
                         input logic [1:0] lt);
    int n;
    @(posedge hclk);
    cpu_req   <= 1'b1;
    cpu_addr  <= ad;
    cpu_write <= wr;
    cpu_byte  <= byt;
    lat       <= lt;
    {cpu_mov_class, cpu_in_repeat, cpu_rpt_first, cpu_rpt_last, cpu_irq_exit, cpu_irq_reentry} <= c;
    @(posedge hclk);
    cpu_req <= 1'b0;
    n = 0;
    // done stands one cycle and may follow the taking edge directly
    #1;
    while (cpu_done !== 1'b1 && n < 40) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (cpu_done !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    hit_q   = cpu_window_hit;
    trap_q  = addr_err_trap;
    extra_q = cpu_extra_cycles;
    dly     = cyc - rv_c;
  endtask : cpu_acc

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, cpu_req, cpu_write, cpu_byte, cpu_addr, cf} = '0;
    {cpu_mov_class, cpu_in_repeat, cpu_rpt_first, cpu_rpt_last, cpu_irq_exit, cpu_irq_reentry} = '0;
    {lat, cyc, rv_c, nreq, miscompares, cmp_count} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, then an unmapped offset
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, 5'(i * 4), 32'h0, rd);
      chk(rd, 32'h0, "reset or unmapped read");
    end
    chk(32'(hresp), 32'h0, "response");
    // page zero read and write in the upper half trap; interrupt masked, unmasked, cleared
    cpu_acc(16'h8000, 1'b0, 1'b0, 6'h20, 2'h0);
    chk(32'(trap_q), 32'h1, "read trap");
    chk(32'(hit_q), 32'h0, "trap hit");
    chk(32'(irq), 32'h0, "irq while masked");
    ahb(1'b0, PSV_OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h1, "trap status");
    ahb(1'b1, PSV_OFF_MASK, 32'h3, rd);
    repeat (2) @(posedge hclk);
    #1;
    chk(32'(irq), 32'h1, "irq unmasked");
    ahb(1'b1, PSV_OFF_STATUS, 32'h1, rd);
    repeat (2) @(posedge hclk);
    #1;
    chk(32'(irq), 32'h0, "irq after clear");
    cpu_acc(16'h9000, 1'b1, 1'b0, 6'h20, 2'h0);
    chk(32'(trap_q), 32'h1, "write trap");
    ahb(1'b1, PSV_OFF_STATUS, 32'h1, rd);
    // every page kind and address corner, word and byte reads, varied flash latency
    foreach (page_t[p]) begin
      pg = page_t[p];
      ahb(1'b1, PSV_OFF_RPAGE, {22'h0, pg}, rd);
      foreach (addr_t[j]) for (int b = 0; b < 2; b++) begin
        a = b ? addr_t[j] : {addr_t[j][15:1], 1'b0};
        pa = {pg[7:0], a[14:1], pg[8]};
        cpu_acc(a, 1'b0, b[0], 6'h20, 2'(j));
        v16 = pg[8] ? {8'h00, pa[7:0] ^ 8'ha5} : pa[15:0];
        chk(32'(hit_q), 32'h1, "window hit");
        chk(32'(prog_addr), 32'(pa), "program address");
        if (b) chk(32'(cpu_rdata[7:0]), 32'(a[0] ? v16[15:8] : v16[7:0]), "byte data");
        else chk(32'(cpu_rdata), 32'(v16), "word data");
      end
      ahb(1'b0, PSV_OFF_LAST, 32'h0, rd);
      chk(rd, 32'(pa), "last address register");
    end
    // no fetch for a disabled page, a lower-half address, or a write into the window
    n0 = nreq;
    ahb(1'b1, PSV_OFF_RPAGE, 32'h102, rd);
    cpu_acc(16'h8000, 1'b0, 1'b0, 6'h20, 2'h0);
    chk(32'({hit_q, trap_q}), 32'h0, "disabled page");
    ahb(1'b1, PSV_OFF_RPAGE, 32'h200, rd);
    cpu_acc(16'h7ffe, 1'b0, 1'b0, 6'h20, 2'h0);
    chk(32'({hit_q, trap_q}), 32'h0, "lower half");
    ahb(1'b1, PSV_OFF_WPAGE, 32'h001, rd);
    cpu_acc(16'h8004, 1'b1, 1'b0, 6'h20, 2'h0);
    chk(32'(trap_q), 32'h0, "write no trap");
    chk(32'(nreq - n0), 32'h0, "fetch count");
    ahb(1'b0, PSV_OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h2, "write drop status");
    chk(32'(irq), 32'h1, "write drop irq");
    ahb(1'b1, PSV_OFF_STATUS, 32'h2, rd);
    // penalty for every repeat case and both classes outside a loop
    for (int i = 0; i < 18; i++) begin
      cf = (i < 16) ? {2'b01, 4'(i)} : {1'(i), 5'h00};
      ex = cf[4] ? ((cf[3:0] != 4'h0) ? PSV_EXTRA_EDGE : PSV_EXTRA_MID) : (cf[5] ? 2'h1 : 2'h2);
      cpu_acc(16'h8010, 1'b0, 1'b0, cf, 2'(i));
      chk(32'(extra_q), 32'(ex), "penalty value");
      chk(32'(cpu_ready), 32'h1, "ready at done");
      chk(32'(dly), 32'(ex) + 32'h1, "penalty delay");
    end
    finish_test();
  end
endmodule : tb_psv_window
